/* hw/frl_regs.vh */
// Register map, field positions and timing constants of the FIFO block
`ifndef FRL_REGS_VH
`define FRL_REGS_VH
// Register offsets
`define FRL_A_STATUS 8'h11
`define FRL_A_LEN0   8'h12
`define FRL_A_LEN1   8'h13
`define FRL_A_DATA   8'h14
`define FRL_A_WTM0   8'h15
`define FRL_A_WTM1   8'h16
`define FRL_A_FCFG   8'h17
`define FRL_A_ICTRL  8'h19
`define FRL_A_CMD    8'h7E
// Commands
`define FRL_CMD_FLUSH 8'hB0
`define FRL_CMD_SRST  8'hB6
// Interrupt control fields
`define FRL_IC_OD    0
`define FRL_IC_LEVEL 1
`define FRL_IC_LATCH 2
`define FRL_IC_FWTM  3
`define FRL_IC_FFULL 4
`define FRL_IC_DRDY  5
`define FRL_ICTRL_RST 8'h02
// FIFO configuration fields
`define FRL_FC_STOP  0
`define FRL_FC_TIME  1
`define FRL_FCFG_RST 8'h00
// Status fields
`define FRL_ST_WTM  0
`define FRL_ST_FULL 1
`define FRL_ST_DRDY 2
// Storage and levels
`define FRL_CAP      10'h200
`define FRL_FULL_LVL 10'h1F8
// Timing
`define FRL_CLK_MHZ     20
`define FRL_DRDY_CLR_US 2500
`endif

/* hw/frl_top.v */
// FIFO readout corner cases and interrupt pad logic of the sensor
`default_nettype none
`include "frl_regs.vh"

// ------------------------------------------------------------
// Staging FIFO
// ------------------------------------------------------------
module frl_stage #(
  parameter W  = 9,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         in_valid,
  output reg          in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0]   cnt_q;
  wire         push = in_valid & in_ready;
  wire         pop  = out_valid & out_ready;
  wire [AW:0]  cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rp_q];

  // Ready is registered so the source never sees a combinational path
  always @(posedge clk) begin
    if (rst) begin
      wp_q     <= {AW{1'b0}};
      rp_q     <= {AW{1'b0}};
      cnt_q    <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        mem[wp_q] <= in_data;
        wp_q      <= wp_q + 1'b1;
      end
      if (pop)
        rp_q <= rp_q + 1'b1;
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != D[AW:0]);
    end
  end
endmodule // frl_stage

// Summary of operation
// - Full frame read: resume at next frame
// - Partial frame: resend whole frame next burst
// - Streaming overwrite: restart at oldest frame
// - Time frame never resent, carries live time
// - Two bits of last byte: frame consumed
// - Past end: one time frame, then empties
// - 0xB0 flushes, 0xB6 soft resets and empties
// - Pad is OR of mapped sources
// - Reset default: push-pull, active high
// - Non-latched: pad follows live conditions
// - Data reads never clear FIFO contributions
// - Latched: pad follows stored status bits
// - Drive type and polarity bits, status untouched
// - One latch bit for pad and status
// - Watermark: count at least level, zero never
// - Watermark re-evaluated at transaction end
// - Full at 504; read clears only below
// - Per-source map enables; latch picks input
// - Data ready set on store, read clears
// - Non-latched data ready self-clears 2.5 ms
// - Late mode or map change waits next event
module frl_top #(
  parameter DRDY_CLR_CYC = `FRL_DRDY_CLR_US * `FRL_CLK_MHZ
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  input  wire        txn_end,
  input  wire [3:0]  txn_last_bits,
  input  wire        src_valid,
  output wire        src_ready,
  input  wire [7:0]  src_data,
  input  wire        src_last,
  input  wire        drdy_evt,
  input  wire [23:0] sensor_time,
  output reg         int_o,
  output reg         int_oe
);
  localparam M_FIFO = 2'd0;
  localparam M_TIME = 2'd1;
  localparam M_EMPT = 2'd2;

  // Bytes in a frame, taken from its header
  function [3:0] frame_len;
    input [7:0] h;
    begin
      case (h[7:6])
        2'b10:   frame_len = 4'd1 + (h[4] ? 4'd3 : 4'd0)
                           + (h[2] ? 4'd3 : 4'd0);
        2'b01:   frame_len = 4'd2;
        default: frame_len = 4'd1;
      endcase
    end
  endfunction

  reg  [7:0]  ram [0:511];
  reg         srst_q;
  wire        rst = sys_rst | srst_q;
  reg  [7:0]  ictrl_q;
  reg  [7:0]  fcfg_q;
  reg  [7:0]  wtm0_q;
  reg         wtm1_q;
  reg  [8:0]  wtm_eff_q;
  reg         wtm_dirty_q;
  reg  [9:0]  cnt_q;
  reg  [8:0]  rbase_q;
  reg  [2:0]  roff_q;
  reg         pend_q;
  reg  [3:0]  plen_q;
  reg  [1:0]  mode_q;
  reg         tdone_q;
  reg  [23:0] tcap_q;
  reg  [8:0]  wbase_q;
  reg  [3:0]  woff_q;
  reg  [3:0]  wlen_q;
  reg         wact_q;
  reg         wdrop_q;
  reg         st_wtm_q;
  reg         st_full_q;
  reg         st_drdy_q;
  reg         drdy_pad_q;
  reg  [15:0] tmr_q;
  reg         tmr_on_q;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire wr_hit    = reg_wr;
  wire cmd_wr    = wr_hit & (reg_addr == `FRL_A_CMD);
  wire flush     = cmd_wr & (reg_wdata == `FRL_CMD_FLUSH);
  wire fetch     = reg_rd & (reg_addr == `FRL_A_DATA);
  wire st_rd     = reg_rd & (reg_addr == `FRL_A_STATUS);
  wire latch     = ictrl_q[`FRL_IC_LATCH];
  wire stop_full = fcfg_q[`FRL_FC_STOP];

  // ------------------------------------------------------------
  // Writer side: staging FIFO into frame RAM
  // ------------------------------------------------------------
  wire [8:0] hd;
  wire       hv;
  wire [9:0] free    = `FRL_CAP - cnt_q;
  wire [3:0] need    = frame_len(hd[7:0]);
  wire       at_hdr  = hv & ~wact_q;
  wire       no_room = at_hdr & (free < {6'd0, need});
  // Oldest frame is evicted only on cycles without reader activity
  wire       evict   = no_room & ~stop_full & ~fetch & ~txn_end
                     & ~flush & (cnt_q != 10'd0);
  wire       wpop    = hv & ~evict;
  wire [3:0] wlen_c  = wact_q ? wlen_q : need;
  wire       wdrop_c = wact_q ? wdrop_q : (no_room & stop_full);
  wire       wcommit = wpop & hd[8] & ~wdrop_c & ~flush;
  wire [3:0] elen    = frame_len(ram[rbase_q]);

  frl_stage #(.W(9), .D(8), .AW(3)) u_stage (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (src_valid),
    .in_ready  (src_ready),
    .in_data   ({src_last, src_data}),
    .out_valid (hv),
    .out_ready (~evict),
    .out_data  (hd)
  );

  // Frame assembly; a frame only counts once its last byte is stored
  always @(posedge clk) begin
    if (rst) begin
      wbase_q <= 9'd0;
      woff_q  <= 4'd0;
      wlen_q  <= 4'd0;
      wact_q  <= 1'b0;
      wdrop_q <= 1'b0;
    end else begin
      if (wpop) begin
        if (~wdrop_c)
          ram[wbase_q + {5'd0, wact_q ? woff_q : 4'd0}] <= hd[7:0];
        wlen_q  <= wlen_c;
        wdrop_q <= wdrop_c | flush;
        woff_q  <= wact_q ? woff_q + 4'd1 : 4'd1;
        wact_q  <= ~hd[8];
        if (wcommit)
          wbase_q <= wbase_q + {5'd0, wlen_c};
      end else if (flush) begin
        wdrop_q <= wact_q;          // Rest of a frame in flight is lost
      end
      if (flush)
        wbase_q <= 9'd0;            // Reader restarts at zero as well
    end
  end

  // ------------------------------------------------------------
  // Reader side
  // ------------------------------------------------------------
  wire [8:0] base_e = pend_q ? rbase_q + {5'd0, plen_q} : rbase_q;
  wire [9:0] cnt_e  = pend_q ? cnt_q - {6'd0, plen_q} : cnt_q;
  wire [3:0] clen   = frame_len(ram[base_e]);
  wire [7:0] fbyte  = ram[base_e + {6'd0, roff_q}];
  reg  [7:0] rbyte;
  reg  [9:0] sub;

  // Byte returned for a data port read
  always @* begin
    rbyte = 8'h00;
    case (mode_q)
      M_FIFO: begin
        if (cnt_e != 10'd0)
          rbyte = fbyte;
        else if (fcfg_q[`FRL_FC_TIME] & ~tdone_q)
          rbyte = 8'hA0;
        else
          rbyte = 8'h80;
      end
      M_TIME:  rbyte = tcap_q[8*(roff_q-3'd1) +: 8];
      M_EMPT:  rbyte = (roff_q == 3'd0) ? 8'h80 : 8'h00;
      default: rbyte = 8'h00;
    endcase
  end

  // Bytes leaving the count this cycle
  always @* begin
    sub = 10'd0;
    if (evict)
      sub = {6'd0, elen};
    else if (fetch & pend_q)
      sub = {6'd0, plen_q};
    else if (txn_end & pend_q & (txn_last_bits >= 4'd2))
      sub = {6'd0, plen_q};
  end

  // Read sequencer: FIFO frames, then one time frame, then empties
  always @(posedge clk) begin
    if (rst | flush) begin
      rbase_q <= 9'd0;
      roff_q  <= 3'd0;
      pend_q  <= 1'b0;
      plen_q  <= 4'd0;
      mode_q  <= M_FIFO;
      tdone_q <= 1'b0;
      tcap_q  <= 24'd0;
    end else if (evict) begin
      rbase_q <= rbase_q + {5'd0, elen};
      roff_q  <= 3'd0;
      pend_q  <= 1'b0;
    end else if (fetch) begin
      case (mode_q)
        M_FIFO: begin
          rbase_q <= base_e;
          pend_q  <= 1'b0;
          if (cnt_e != 10'd0) begin
            if ({1'b0, roff_q} + 4'd1 == clen) begin
              pend_q <= 1'b1;
              plen_q <= clen;
              roff_q <= 3'd0;
            end else begin
              roff_q <= roff_q + 3'd1;
            end
          end else if (fcfg_q[`FRL_FC_TIME] & ~tdone_q) begin
            mode_q <= M_TIME;
            roff_q <= 3'd1;
            tcap_q <= sensor_time;
          end else begin
            mode_q <= M_EMPT;
            roff_q <= 3'd1;
          end
        end
        M_TIME: begin
          if (roff_q == 3'd3) begin
            mode_q  <= M_EMPT;
            roff_q  <= 3'd0;
            tdone_q <= 1'b1;
          end else begin
            roff_q <= roff_q + 3'd1;
          end
        end
        M_EMPT:  roff_q <= ~roff_q[0] ? 3'd1 : 3'd0;
        default: mode_q <= M_FIFO;
      endcase
    end else if (txn_end) begin
      // Burst over: any time frame in progress is simply dropped
      mode_q  <= M_FIFO;
      tdone_q <= 1'b0;
      roff_q  <= 3'd0;
      pend_q  <= 1'b0;
      if (pend_q & (txn_last_bits >= 4'd2))
        rbase_q <= base_e;
    end
  end

  // Fill count moves by whole frames only
  always @(posedge clk) begin
    if (rst | flush)
      cnt_q <= 10'd0;
    else
      cnt_q <= cnt_q + (wcommit ? {6'd0, wlen_c} : 10'd0) - sub;
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      ictrl_q     <= `FRL_ICTRL_RST;
      fcfg_q      <= `FRL_FCFG_RST;
      wtm0_q      <= 8'h00;
      wtm1_q      <= 1'b0;
      wtm_eff_q   <= 9'd0;
      wtm_dirty_q <= 1'b0;
    end else begin
      if (wr_hit & (reg_addr == `FRL_A_ICTRL))
        ictrl_q <= reg_wdata;
      if (wr_hit & (reg_addr == `FRL_A_FCFG))
        fcfg_q <= reg_wdata;
      if (wr_hit & (reg_addr == `FRL_A_WTM0))
        wtm0_q <= reg_wdata;
      if (wr_hit & (reg_addr == `FRL_A_WTM1))
        wtm1_q <= reg_wdata[0];
      // Level takes effect only when the transaction closes
      if (txn_end) begin
        wtm_dirty_q <= 1'b0;
        if (wtm_dirty_q)
          wtm_eff_q <= {wtm1_q, wtm0_q};
      end else if (wr_hit & ((reg_addr == `FRL_A_WTM0) |
                             (reg_addr == `FRL_A_WTM1))) begin
        wtm_dirty_q <= 1'b1;
      end
    end
  end

  // Soft reset pulse clears every register the cycle after the write
  always @(posedge clk) begin
    if (sys_rst)
      srst_q <= 1'b0;
    else
      srst_q <= cmd_wr & (reg_wdata == `FRL_CMD_SRST);
  end

  // Read data, one cycle after the request
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      case (reg_addr)
        `FRL_A_STATUS: reg_rdata <= {5'd0, st_drdy_q, st_full_q,
                                     st_wtm_q};
        `FRL_A_LEN0:   reg_rdata <= cnt_q[7:0];
        `FRL_A_LEN1:   reg_rdata <= {7'd0, cnt_q[8]};
        `FRL_A_DATA:   reg_rdata <= rbyte;
        `FRL_A_WTM0:   reg_rdata <= wtm0_q;
        `FRL_A_WTM1:   reg_rdata <= {7'd0, wtm1_q};
        `FRL_A_FCFG:   reg_rdata <= fcfg_q;
        `FRL_A_ICTRL:  reg_rdata <= ictrl_q;
        default:       reg_rdata <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Interrupt sources and status
  // ------------------------------------------------------------
  wire c_wtm  = (wtm_eff_q != 9'd0) &
                (cnt_q >= {1'b0, wtm_eff_q});
  wire c_full = (cnt_q >= `FRL_FULL_LVL);
  wire tmr_end = tmr_on_q &
                 (tmr_q == DRDY_CLR_CYC[15:0] - 16'd1);

  // Status bits; a new event in the read cycle wins over the clear
  always @(posedge clk) begin
    if (rst) begin
      st_wtm_q  <= 1'b0;
      st_full_q <= 1'b0;
      st_drdy_q <= 1'b0;
    end else begin
      if (latch) begin
        st_wtm_q  <= c_wtm | (st_wtm_q & ~st_rd);
        st_full_q <= c_full | (st_full_q & ~st_rd);
      end else begin
        st_wtm_q  <= c_wtm;
        st_full_q <= c_full;
      end
      st_drdy_q <= drdy_evt | (st_drdy_q & ~st_rd);
    end
  end

  // Data ready pad term and its self-clear timer
  always @(posedge clk) begin
    if (rst) begin
      drdy_pad_q <= 1'b0;
      tmr_q      <= 16'd0;
      tmr_on_q   <= 1'b0;
    end else if (drdy_evt) begin
      // Only an event arms the term, so late enables wait for one
      drdy_pad_q <= ictrl_q[`FRL_IC_DRDY];
      tmr_on_q   <= ~latch;
      tmr_q      <= 16'd0;
    end else begin
      if (st_rd | tmr_end)
        drdy_pad_q <= 1'b0;
      if (tmr_end | st_rd)
        tmr_on_q <= 1'b0;
      tmr_q <= tmr_on_q ? tmr_q + 16'd1 : 16'd0;
    end
  end

  // ------------------------------------------------------------
  // Pad
  // ------------------------------------------------------------
  // Data port reads have no path here; only conditions or status do
  wire src_wtm  = latch ? st_wtm_q  : c_wtm;
  wire src_full = latch ? st_full_q : c_full;
  wire act = (ictrl_q[`FRL_IC_FWTM]  & src_wtm)
           | (ictrl_q[`FRL_IC_FFULL] & src_full)
           | drdy_pad_q;
  wire lvl = ictrl_q[`FRL_IC_LEVEL] ? act : ~act;

  // Open drain only ever pulls low; push-pull always drives
  always @(posedge clk) begin
    if (rst) begin
      int_o  <= 1'b0;
      int_oe <= 1'b1;
    end else if (ictrl_q[`FRL_IC_OD]) begin
      int_o  <= 1'b0;
      int_oe <= ~lvl;
    end else begin
      int_o  <= lvl;
      int_oe <= 1'b1;
    end
  end
endmodule // frl_top
`default_nettype wire

/* sim/frl_top_properties.sv */
// Checker of pad and register port timing
`default_nettype none
`include "frl_regs.vh"
module frl_top_properties #(
  parameter int DRDY_CLR_CYC = 20
) (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic       reg_rvalid,
  input wire logic       drdy_evt,
  input wire logic       int_o,
  input wire logic       int_oe
);
  localparam logic [15:0] LIM = 16'(DRDY_CLR_CYC + 5);
  logic [7:0]  ic_q, ic1_q, ic2_q, ic3_q;
  logic [15:0] cnt_q;
  logic        st, srst, n22;
  // ----------
  // Helpers
  // ----------
  // Pad control shadow; three equal stages mean the pad has caught up
  assign srst = reg_wr && reg_addr == `FRL_A_CMD
                && reg_wdata == `FRL_CMD_SRST;
  assign st = ic_q == ic1_q && ic1_q == ic2_q && ic2_q == ic3_q;
  assign n22 = st && ic_q == 8'h22;
  always_ff @(posedge clk) begin
    if (sys_rst || srst) begin
      ic_q <= `FRL_ICTRL_RST;
    end else if (reg_wr && reg_addr == `FRL_A_ICTRL) begin
      ic_q <= reg_wdata;
    end
    ic1_q <= ic_q;
    ic2_q <= ic1_q;
    ic3_q <= ic2_q;
  end
  // Age of a data-ready event seen in non-latched mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 16'h0000;
    end else if (drdy_evt && n22) begin
      cnt_q <= 16'h0001;
    end else if (cnt_q != 16'h0000 && cnt_q <= LIM) begin
      cnt_q <= cnt_q + 16'h0001;
    end else begin
      cnt_q <= 16'h0000;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ----------
  // Properties
  // ----------
  chk_read_answer: assert property (
    reg_rd |=> reg_rvalid) else $error("read not answered");
  chk_answer_cause: assert property (
    reg_rvalid |-> $past(reg_rd)) else $error("answer without read");
  chk_reset_pad: assert property (
    $fell(sys_rst) |-> int_oe && !int_o) else $error("pad not idle");
  chk_softrst_pad: assert property (
    srst |-> ##3 (int_oe && !int_o)) else $error("soft reset pad");
  chk_pp_drive: assert property (
    st && !ic_q[0] |-> int_oe) else $error("push-pull not driving");
  chk_idle_level: assert property (
    st && ic_q[5:3] == 3'b000 && !ic_q[0] |-> int_o == !ic_q[1])
    else $error("idle level wrong");
  chk_od_release: assert property (
    st && ic_q[5:3] == 3'b000 && ic_q[0] |-> !int_oe)
    else $error("open drain not released");
  chk_drdy_clear: assert property (
    n22 && cnt_q == LIM |-> !int_o) else $error("no self clear");
  chk_drdy_cause: assert property (
    n22 && $rose(int_o) |-> $past(drdy_evt, 2))
    else $error("pad rose without event");
  chk_drdy_to_pad: assert property (
    n22 && drdy_evt && !reg_rd |-> ##2 int_o) else $error("pad missed");
  chk_latch_hold: assert property (
    st && ic_q == 8'h26 && int_o && !reg_rd && !reg_wr && !$past(reg_rd)
    |=> int_o) else $error("latched pad dropped");
endmodule // frl_top_properties
bind frl_top frl_top_properties #(.DRDY_CLR_CYC(DRDY_CLR_CYC)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid),
  .drdy_evt(drdy_evt), .int_o(int_o), .int_oe(int_oe));
`default_nettype wire

/* sim/frl_host_model.sv */
// Host model driving register accesses and burst ends
`default_nettype none
module frl_host_model (
  input  wire logic       clk,
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output var  logic       txn_end,
  output var  logic [3:0] txn_last_bits
);
  // Idle bus from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    txn_end = 1'b0;
    txn_last_bits = 4'h0;
  end
  // Write; released data turns to its inverse so stale bytes never match
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask
  // Read; the answer stands in the cycle after the request
  task automatic rd(input logic [7:0] a, output logic [7:0] v,
                    output logic ok);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    ok = reg_rvalid;
    v = reg_rdata;
  endtask
  // Burst end with the bits of the last byte shifted out
  task automatic end_txn(input logic [3:0] b);
    @(negedge clk);
    txn_end = 1'b1;
    txn_last_bits = b;
    @(negedge clk);
    txn_end = 1'b0;
    txn_last_bits = ~b;
  endtask
endmodule // frl_host_model
`default_nettype wire

/* sim/fifo_readout_and_interrupt_logic_tb_top.sv */
// Self-checking bench of the FIFO readout and pad block
`default_nettype none
`include "frl_regs.vh"
module fifo_readout_and_interrupt_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CLR = 20;
  logic        clk, sys_rst, reg_wr, reg_rd, reg_rvalid, txn_end;
  logic        src_valid, src_ready, src_last, drdy_evt, int_o, int_oe;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, src_data, d;
  logic [3:0]  txn_last_bits;
  logic [23:0] sensor_time, tm;
  logic [31:0] seed = 32'h594404FD;
  logic [7:0]  fq[$];
  int          bad_count = 0;
  int          compares = 0;
  frl_top #(.DRDY_CLR_CYC(CLR)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .txn_end(txn_end),
    .txn_last_bits(txn_last_bits), .src_valid(src_valid),
    .src_ready(src_ready), .src_data(src_data), .src_last(src_last),
    .drdy_evt(drdy_evt), .sensor_time(sensor_time), .int_o(int_o),
    .int_oe(int_oe));
  frl_host_model u_host (
    .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .txn_end(txn_end), .txn_last_bits(txn_last_bits));
  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------
  // Helpers
  // ----------
  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic wrap_up();
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tmo();
    bad_count++;
    wrap_up();
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                     input logic [7:0] m = 8'hFF);
    logic ok;
    u_host.rd(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d & m, e);
  endtask
  // Pad gets two cycles of latency per cause, plus margin
  task automatic pad(input logic [1:0] e, input logic [1:0] m = 2'b11);
    repeat (4) @(negedge clk);
    chk({6'h00, {int_oe, int_o} & m}, {6'h00, e});
  endtask
  task automatic pulse();
    repeat (3) @(negedge clk);
    drdy_evt = 1'b1;
    @(negedge clk);
    drdy_evt = 1'b0;
  endtask
  // One 7-byte pressure and temperature frame, expected bytes queued
  task automatic push();
    int k;
    @(negedge clk);
    for (int i = 0; i < 7; i++) begin
      src_data = i == 0 ? 8'h94 : rnd8();
      src_last = i == 6;
      src_valid = 1'b1;
      fq.push_back(src_data);
      for (k = 0; k < 99 && src_ready !== 1'b1; k++) @(negedge clk);
      if (k == 99) tmo();
      @(negedge clk);
    end
    src_valid = 1'b0;
    src_data = ~src_data;
  endtask
  task automatic rdf(input int s, input int n);
    for (int i = 0; i < n; i++) rdc(`FRL_A_DATA, fq[s + i]);
  endtask
  // Polls the byte count; bounded
  task automatic wait_len(input logic [8:0] e);
    logic ok;
    logic [7:0] lo;
    for (int k = 0; k < 50; k++) begin
      u_host.rd(`FRL_A_LEN0, lo, ok);
      u_host.rd(`FRL_A_LEN1, d, ok);
      if ({d[0], lo} === e) break;
    end
    chk(lo, e[7:0]);
    chk(d & 8'h01, {7'h00, e[8]});
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    tmo();
  end
  // ----------
  // Scenarios
  // ----------
  initial begin
    sys_rst = 1'b1;
    {src_valid, src_last, drdy_evt, src_data} = 11'h000;
    sensor_time = 24'h000000;
    repeat (5) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    pad(2'b10);
    rdc(`FRL_A_ICTRL, `FRL_ICTRL_RST);
    rdc(`FRL_A_FCFG, `FRL_FCFG_RST);
    rdc(8'h20, 8'h00);
    push();
    push();
    wait_len(9'd14);
    rdf(0, 7);
    u_host.end_txn(4'h8);
    wait_len(9'd7);
    rdf(7, 1 + rnd8() % 6);
    u_host.end_txn(4'h8);
    rdf(7, 7);
    u_host.end_txn(4'h2);
    wait_len(9'd0);
    // Over-read with and without the time frame
    u_host.wr(`FRL_A_FCFG, 8'h02);
    sensor_time = {rnd8(), rnd8(), rnd8()};
    rdc(`FRL_A_DATA, 8'hA0);
    rdc(`FRL_A_DATA, sensor_time[7:0]);
    u_host.end_txn(4'h8);
    sensor_time = {rnd8(), rnd8(), rnd8()};
    tm = sensor_time;
    rdc(`FRL_A_DATA, 8'hA0);
    // Counter moves on mid-frame; payload keeps the value at its start
    sensor_time = ~tm;
    for (int i = 0; i < 3; i++) rdc(`FRL_A_DATA, tm[8*i+:8]);
    for (int i = 0; i < 4; i++) rdc(`FRL_A_DATA, i[0] ? 8'h00 : 8'h80);
    u_host.end_txn(4'h8);
    u_host.wr(`FRL_A_FCFG, 8'h00);
    rdc(`FRL_A_DATA, 8'h80);
    u_host.end_txn(4'h8);
    // Watermark: zero never fires, then the boundary level of 7
    u_host.wr(`FRL_A_WTM0, 8'h00);
    u_host.wr(`FRL_A_WTM1, 8'h00);
    u_host.end_txn(4'h8);
    u_host.wr(`FRL_A_ICTRL, 8'h0A);
    fq.delete();
    push();
    wait_len(9'd7);
    pad(2'b10);
    u_host.wr(`FRL_A_WTM0, 8'h07);
    u_host.wr(`FRL_A_WTM1, 8'h00);
    u_host.end_txn(4'h8);
    pad(2'b11);
    rdc(`FRL_A_STATUS, 8'h01, 8'h01);
    rdf(0, 3);
    pad(2'b11);
    u_host.end_txn(4'h8);
    rdf(0, 7);
    u_host.end_txn(4'h8);
    wait_len(9'd0);
    pad(2'b10);
    // Full at 504 bytes, then flush
    u_host.wr(`FRL_A_ICTRL, 8'h12);
    for (int f = 0; f < 72; f++) push();
    wait_len(9'd504);
    pad(2'b11);
    rdc(`FRL_A_STATUS, 8'h02, 8'h02);
    rdc(`FRL_A_STATUS, 8'h02, 8'h02);
    // Overwrite while partially read: next oldest kept frame comes next
    rdf(7, 3);
    u_host.end_txn(4'h8);
    push();
    push();
    wait_len(9'd511);
    rdf(14, 7);
    u_host.end_txn(4'h8);
    u_host.wr(`FRL_A_CMD, `FRL_CMD_FLUSH);
    wait_len(9'd0);
    pad(2'b10);
    fq.delete();
    // Data ready, non-latched then latched; late enable waits an event
    pulse();
    u_host.wr(`FRL_A_ICTRL, 8'h22);
    pad(2'b10);
    pulse();
    pad(2'b11);
    repeat (CLR) @(negedge clk);
    pad(2'b10);
    rdc(`FRL_A_STATUS, 8'h04, 8'h04);
    rdc(`FRL_A_STATUS, 8'h00, 8'h04);
    u_host.wr(`FRL_A_ICTRL, 8'h26);
    pulse();
    repeat (CLR) @(negedge clk);
    pad(2'b11);
    rdc(`FRL_A_STATUS, 8'h04, 8'h04);
    pad(2'b10);
    // Active low push-pull, then open drain
    u_host.wr(`FRL_A_ICTRL, 8'h00);
    pad(2'b11);
    u_host.wr(`FRL_A_ICTRL, 8'h01);
    pad(2'b00, 2'b10);
    u_host.wr(`FRL_A_ICTRL, 8'h21);
    pad(2'b00, 2'b10);
    pulse();
    pad(2'b10);
    rdc(`FRL_A_STATUS, 8'h04, 8'h04);
    pad(2'b00, 2'b10);
    // Soft reset empties storage and restores the pad
    push();
    wait_len(9'd7);
    rdf(0, 7);
    u_host.wr(`FRL_A_CMD, `FRL_CMD_SRST);
    repeat (2) @(negedge clk);
    rdc(`FRL_A_ICTRL, `FRL_ICTRL_RST);
    wait_len(9'd0);
    pad(2'b10);
    wrap_up();
  end
endmodule // fifo_readout_and_interrupt_logic_tb_top
`default_nettype wire
